/* core/lpc_pkg.sv */
// Constants and types shared by the low-power clock controller.
// Assumes a single 40 MHz controller clock.
package lpc_pkg;
   // Controller clock period
   localparam int CLK_PERIOD_NS = 25;
   // Oscillator start-up time after the halt level
   localparam int OSC_SETTLE_NS = 1000;
   // PLL lock time once the oscillator runs
   localparam int PLL_LOCK_NS   = 10000;
   // Least times round up to whole cycles
   localparam int OSC_CYC = (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PLL_CYC = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Width of the settle counter
   localparam int CNT_W = 10;

   // Low-power select field values, taken from bits [13:12]
   localparam logic [1:0] SEL_LIGHT = 2'h0;
   localparam logic [1:0] SEL_DEEP  = 2'h1;
   localparam int         SEL_HALT_BIT = 1;
   // Select field position inside the system control register
   localparam int SEL_MSB = 13;
   localparam int SEL_LSB = 12;

   // Peripheral clock enable bit positions
   localparam int PER_ADC  = 0;
   localparam int PER_SER  = 1;
   localparam int PER_SPI  = 2;
   localparam int PER_CAN  = 3;
   localparam int PER_EVT_B = 4;
   localparam int PER_EVT_A = 5;
   localparam int PER_N    = 6;
   localparam logic [PER_N-1:0] PER_RESET = 6'h00;

   // Controller states
   typedef enum logic [2:0] {
      ST_RUN, ST_LIGHT, ST_DEEP, ST_HALT, ST_OSC, ST_PLL, ST_SYS
   } lpc_state_t;

   // Clock and power enables driven to the clock tree
   typedef struct packed {
      logic cpu;    // CPU clock domain
      logic sys;    // System domain and cpu_clock_output
      logic wdog;   // watchdog_clock
      logic pll;    // PLL running
      logic osc;    // Oscillator running
      logic flash;  // Flash power
   } lpc_pwr_t;

   // Wake sources
   typedef struct packed {
      logic periph;   // Peripheral interrupt
      logic wakeup;   // Wakeup interrupt, alive in deep sleep
      logic ext;      // External interrupt pin
      logic protect;  // power_drive_protect_input pin
   } lpc_wake_t;

   localparam lpc_pwr_t PWR_ALL_ON = 6'h3f;
endpackage

/* core/lpc_sync.sv */
// Two-stage synchroniser for asynchronous pins.
// Assumes the reset given is already synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module lpc_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   // First stage, read only by the second
   logic [W-1:0] meta_q;

   // Two flops, cleared by reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule
`default_nettype wire

/* core/lpc_ctrl.sv */
// Low-power mode and clock-gating controller.
// Assumes clock gates downstream latch these enables glitch-free.
//
// Notes on behaviour
// - Light sleep stops CPU clocks, clock output runs
// - Reset or interrupt ends light or deep sleep; light ignores the wakeup interrupt, deep ignores the peripheral interrupt
// - Separate CPU and system clock domains
// - Select bits 13:12 pick sleep depth
// - Light level stops only CPU domain
// - Deep level stops CPU and system
// - Halt adds oscillator, watchdog, PLL and flash off
// - Halt: all off, protect/reset exit
// - Peripheral clock enables, off at reset
`timescale 1ns/100ps
`default_nettype none
module lpc_ctrl #(
   parameter int OSC_CYCLES = lpc_pkg::OSC_CYC,
   parameter int PLL_CYCLES = lpc_pkg::PLL_CYC
) (
   input  wire logic                       CLK,
   input  wire logic                       RST_N,
   input  wire logic                       SLEEP_REQ,
   input  wire logic [1:0]                 LOW_POWER_SEL,
   input  wire lpc_pkg::lpc_wake_t         WAKE,
   input  wire logic                       PER_EN_WR,
   input  wire logic [lpc_pkg::PER_N-1:0]  PER_EN_DATA,
   output lpc_pkg::lpc_pwr_t               PWR,
   output logic [lpc_pkg::PER_N-1:0]       PER_CLK_EN,
   output logic                            ASLEEP
);
   import lpc_pkg::*;

   // Counts the logic cannot serve
   if (OSC_CYCLES < 1 || OSC_CYCLES >= 2**CNT_W ||
       PLL_CYCLES < 1 || PLL_CYCLES >= 2**CNT_W) begin : g_chk
      $error("settle counts out of range");
   end

   logic [1:0]        rst_q;        // Reset release chain
   logic              rst_n_s;      // Synchronised reset
   logic              ext_s;        // Synchronised external irq
   logic              prot_s;       // Synchronised protect pin
   lpc_state_t        state_q;      // Current level
   lpc_state_t        state_d;      // Next level
   logic [CNT_W-1:0]  cnt_q;        // Settle counter
   logic              cnt_done;     // Counter reached zero
   logic [PER_N-1:0]  per_en_q;     // Software peripheral enables
   lpc_pwr_t          pwr_d;        // Enables for the next state

   // Reset asserts at once, releases after two edges
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rst_q <= 2'h0;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_n_s = rst_q[1];

   // Pins come from outside the clock domain
   lpc_sync #(.W(2)) u_sync (
      .clk   (CLK),
      .rst_n (rst_n_s),
      .d     ({WAKE.ext, WAKE.protect}),
      .q     ({ext_s, prot_s})
   );

   assign cnt_done = (cnt_q == '0);

   // Level sequencing
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_RUN: begin
            if (SLEEP_REQ) begin
               if (LOW_POWER_SEL[SEL_HALT_BIT]) begin
                  state_d = ST_HALT;
               end else if (LOW_POWER_SEL == SEL_DEEP) begin
                  state_d = ST_DEEP;
               end else begin
                  state_d = ST_LIGHT;
               end
            end
         end
         ST_LIGHT: begin
            if (WAKE.periph || ext_s || prot_s) begin
               state_d = ST_RUN;
            end
         end
         ST_DEEP: begin
            if (WAKE.wakeup || ext_s || prot_s) begin
               state_d = ST_SYS;
            end
         end
         ST_HALT: begin
            if (prot_s) begin
               state_d = ST_OSC;
            end
         end
         ST_OSC: begin
            if (cnt_done) begin
               state_d = ST_PLL;
            end
         end
         ST_PLL: begin
            if (cnt_done) begin
               state_d = ST_SYS;
            end
         end
         ST_SYS: begin
            // system opens a cycle before CPU
            state_d = ST_RUN;
         end
      endcase
   end

   // Enables belonging to each level
   always_comb begin
      pwr_d = PWR_ALL_ON;
      unique case (state_d)
         ST_RUN: begin
            pwr_d = PWR_ALL_ON;
         end
         ST_LIGHT: begin
            pwr_d.cpu = 1'b0;
         end
         ST_DEEP: begin
            pwr_d.cpu = 1'b0;
            pwr_d.sys = 1'b0;
         end
         ST_HALT: begin
            // deep plus oscillator, watchdog, PLL and flash off
            pwr_d = '0;
         end
         ST_OSC: begin
            // Oscillator and flash come back first
            pwr_d = '0;
            pwr_d.osc   = 1'b1;
            pwr_d.flash = 1'b1;
         end
         ST_PLL: begin
            // PLL added, domains still closed
            pwr_d = '0;
            pwr_d.osc   = 1'b1;
            pwr_d.flash = 1'b1;
            pwr_d.pll   = 1'b1;
         end
         ST_SYS: begin
            pwr_d.cpu = 1'b0;
         end
      endcase
   end

   // State register
   always_ff @(posedge CLK or negedge rst_n_s) begin
      if (!rst_n_s) begin
         state_q <= ST_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   // settle counter loaded on each wait entry
   always_ff @(posedge CLK or negedge rst_n_s) begin
      if (!rst_n_s) begin
         cnt_q <= '0;
      end else if (state_q == ST_HALT) begin
         cnt_q <= CNT_W'(OSC_CYCLES - 1);
      end else if (state_q == ST_OSC && cnt_done) begin
         cnt_q <= CNT_W'(PLL_CYCLES - 1);
      end else if (!cnt_done) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge rst_n_s) begin
      if (!rst_n_s) begin
         per_en_q <= PER_RESET;
      end else if (PER_EN_WR) begin
         per_en_q <= PER_EN_DATA;
      end
   end

   // Outputs straight from flops; peripheral clocks follow system domain
   always_ff @(posedge CLK or negedge rst_n_s) begin
      if (!rst_n_s) begin
         PWR        <= PWR_ALL_ON;
         PER_CLK_EN <= PER_RESET;
         ASLEEP     <= 1'b0;
      end else begin
         PWR        <= pwr_d;
         PER_CLK_EN <= per_en_q & {PER_N{pwr_d.sys}};
         ASLEEP     <= (state_d != ST_RUN);
      end
   end

   // Checks
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!rst_n_s);

   light_entry_a: assert property (
      state_q == ST_RUN && SLEEP_REQ && LOW_POWER_SEL == SEL_LIGHT |=>
      !PWR.cpu && PWR.sys && PWR.wdog && PWR.pll && PWR.osc && PWR.flash)
      else $error("light level enables wrong");
   deep_entry_a: assert property (
      state_q == ST_RUN && SLEEP_REQ && LOW_POWER_SEL == SEL_DEEP |=>
      !PWR.cpu && !PWR.sys && PWR.wdog && PWR.pll && PWR.osc)
      else $error("deep level enables wrong");
   halt_entry_a: assert property (
      state_q == ST_RUN && SLEEP_REQ && LOW_POWER_SEL[SEL_HALT_BIT] |=>
      PWR == '0)
      else $error("halt level not all off");
   halt_osc_a: assert property (
      state_q == ST_HALT |-> !PWR.osc && !PWR.wdog)
      else $error("oscillator or watchdog on in halt");
   halt_stay_a: assert property (
      state_q == ST_HALT && !prot_s |=> state_q == ST_HALT)
      else $error("halt left without protect");
   cpu_clock_output_run_a: assert property (
      state_q == ST_LIGHT |-> PWR.sys && !PWR.cpu)
      else $error("clock output stopped in light level");
   light_wake_a: assert property (
      state_q == ST_LIGHT && (WAKE.periph || ext_s) |=> PWR.cpu && !ASLEEP)
      else $error("light level did not wake");
   deep_wake_a: assert property (
      state_q == ST_DEEP && WAKE.wakeup |=> PWR.sys && !PWR.cpu ##1 PWR.cpu)
      else $error("deep wake order wrong");
   sys_before_cpu_a: assert property (
      $rose(PWR.cpu) |-> $past(PWR.sys))
      else $error("CPU opened before system domain");
   // One cycle is all a count of one guarantees; the bench times the rest
   halt_settle_a: assert property (
      state_q == ST_HALT && prot_s |=> PWR.osc && !PWR.pll)
      else $error("PLL started before oscillator settle");
   sys_after_pll_a: assert property (
      $rose(PWR.sys) |-> $past(PWR.pll) && $past(PWR.osc))
      else $error("system domain opened before PLL running");
   per_gate_a: assert property (
      !PWR.sys |-> PER_CLK_EN == '0)
      else $error("peripheral clock with system domain stopped");

   cover property (state_q == ST_LIGHT ##1 state_q == ST_RUN);
   cover property (state_q == ST_DEEP ##1 state_q == ST_SYS);
   cover property (state_q == ST_PLL ##1 state_q == ST_SYS);
   cover property (PER_EN_WR && PER_EN_DATA != '0);
endmodule
`default_nettype wire

/* verification/lpc_periph_model.sv */
// Peripheral model: raises its interrupt only while its clock runs.
// Assumes the controller's clock and reset.
`timescale 1ns/100ps
`default_nettype none
module lpc_periph_model (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic sys_en,
   input  wire logic fire,
   input  wire logic ack,
   output logic      irq
);
   logic pend_q; // Event waiting for service

   // Event held until acknowledged
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_q <= 1'b0;
      end else if (ack) begin
         pend_q <= 1'b0;
      end else if (fire) begin
         pend_q <= 1'b1;
      end
   end

   // A stopped peripheral cannot interrupt
   assign irq = pend_q & sys_en;
endmodule
`default_nettype wire

/* verification/tb_low_power_clock_gating.sv */
// Self-checking bench for the low-power clock controller.
// Assumes short settle counts so halt exits stay brief.
`timescale 1ns/100ps
`default_nettype none
module tb_low_power_clock_gating;
   import lpc_pkg::*;
   localparam int OSC_N = 2; // Short oscillator wait
   localparam int PLL_N = 3; // Short PLL wait
   logic             clk, rst_n, sleep_req, per_wr, fire, ack;
   logic             tb_periph, wk_up, wk_ext, wk_prot, asleep, model_irq;
   logic [1:0]       sel;
   logic [PER_N-1:0] per_data, per_en;
   lpc_wake_t        wake;
   lpc_pwr_t         pwr;
   int               error_cnt, samples_checked;

   // Peripheral line shared by the model and the bench
   assign wake = '{model_irq | tb_periph, wk_up, wk_ext, wk_prot};

   lpc_ctrl #(.OSC_CYCLES(OSC_N), .PLL_CYCLES(PLL_N)) lpc_ctrl_i (
      .CLK(clk), .RST_N(rst_n), .SLEEP_REQ(sleep_req), .LOW_POWER_SEL(sel),
      .WAKE(wake), .PER_EN_WR(per_wr), .PER_EN_DATA(per_data),
      .PWR(pwr), .PER_CLK_EN(per_en), .ASLEEP(asleep));
   lpc_periph_model lpc_periph_model_i (
      .clk(clk), .rst_n(rst_n), .sys_en(pwr.sys), .fire(fire), .ack(ack),
      .irq(model_irq));

   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Inputs move 1 ns after the edge, clear of sampling
   task automatic tick(input int n = 1);
      repeat (n) @(posedge clk) #1;
   endtask
   task automatic chk(input logic [5:0] got, input logic [5:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Bounded wait for one enable bit of PWR
   task automatic wait_bit(input int b);
      for (int i = 0; i < 8 && pwr[b] !== 1'b1; i++) tick();
      if (pwr[b] !== 1'b1) begin
         error_cnt++;
         $display("ERROR t=%0t wake timed out", $time);
         tally_and_finish();
      end
   endtask
   task automatic sleep(input logic [1:0] s);
      sel <= s;
      sleep_req <= 1'b1;
      tick();
      sleep_req <= 1'b0;
   endtask

   task automatic t_per;
      chk(per_en, 6'h00);
      per_wr <= 1'b1;
      for (int i = 0; i < PER_N; i++) begin
         per_data <= 6'h01 << i;
         tick();
      end
      per_data <= 6'h3f;
      tick();
      chk(per_en, 6'h20);
      per_wr <= 1'b0;
      tick();
      chk(per_en, 6'h3f);
      $display("peripheral enable test done");
   endtask

   task automatic t_light;
      sleep(2'b00);
      chk(pwr, 6'h1f);
      chk({5'h0, asleep}, 6'h01);
      chk(per_en, 6'h3f);
      fire <= 1'b1;
      tick();
      fire <= 1'b0;
      tick();
      chk(pwr, 6'h3f);
      ack <= 1'b1;
      tick();
      ack <= 1'b0;
      $display("light sleep test done");
   endtask

   task automatic t_deep(input logic use_ext);
      sleep(2'b01);
      chk(pwr, 6'h0f);
      tb_periph <= 1'b1;
      tick(3);
      chk(pwr, 6'h0f);
      chk(per_en, 6'h00);
      tb_periph <= 1'b0;
      if (use_ext) wk_ext <= 1'b1;
      else wk_up <= 1'b1;
      wait_bit(4);
      chk(pwr, 6'h1f);
      wk_ext <= 1'b0;
      wk_up <= 1'b0;
      tick();
      chk(pwr, 6'h3f);
      tick(3);
      chk(per_en, 6'h3f);
      $display("deep sleep test done");
   endtask

   task automatic t_halt(input logic [1:0] s);
      sleep(s);
      chk(pwr, 6'h00);
      {tb_periph, wk_up, wk_ext} <= 3'h7;
      tick(5);
      chk(pwr, 6'h00);
      {tb_periph, wk_up, wk_ext} <= 3'h0;
      wk_prot <= 1'b1;
      wait_bit(1);
      chk(pwr, 6'h03);
      wk_prot <= 1'b0;
      tick(OSC_N - 1);
      chk(pwr, 6'h03);
      tick();
      chk(pwr, 6'h07);
      tick(PLL_N - 1);
      chk(pwr, 6'h07);
      tick();
      chk(pwr, 6'h1f);
      tick();
      chk(pwr, 6'h3f);
      chk({5'h0, asleep}, 6'h00);
      tick(3);
      $display("halt test done");
   endtask

   // Reset in mid-sleep restores clocks and clears enables
   task automatic t_reset;
      sleep(2'b01);
      rst_n <= 1'b0;
      tick();
      chk(pwr, 6'h3f);
      chk(per_en, 6'h00);
      rst_n <= 1'b1;
      tick();
      chk(pwr, 6'h3f);
      chk({5'h0, asleep}, 6'h00);
      tick();
      chk(pwr, 6'h3f);
      chk(per_en, 6'h00);
      // First request lands on the third edge after release
      sleep(2'b00);
      chk(pwr, 6'h1f);
      wk_prot <= 1'b1;
      wait_bit(5);
      chk(pwr, 6'h3f);
      chk({5'h0, asleep}, 6'h00);
      wk_prot <= 1'b0;
      tick(3);
      $display("reset test done");
   endtask

   initial begin
      {rst_n, sleep_req, per_wr, fire, ack} = 5'h0;
      {tb_periph, wk_up, wk_ext, wk_prot} = 4'h0;
      sel = 2'h0;
      per_data = 6'h00;
      error_cnt = 0;
      samples_checked = 0;
      tick(5);
      rst_n <= 1'b1;
      tick(3);
      chk(pwr, 6'h3f);
      t_per();
      t_light();
      t_deep(1'b0);
      t_deep(1'b1);
      t_halt(2'b10);
      t_halt(2'b11);
      t_reset();
      tally_and_finish();
   end
endmodule
`default_nettype wire
